// file: machine_cycle_tick.v
// Purpose: One-clock pulse at the end of every machine cycle
// Assumes: Machine cycle is a whole number of system clocks
// Notes:   Free running so the trigger pin is still watched in Idle
`timescale 1ns/1ps
`default_nettype none
module machine_cycle_tick #(
  parameter CLKS_PER_MC = 12
) (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // Machine cycle end strobe
  output wire       tick_out
);
  localparam integer LAST_I = CLKS_PER_MC - 1;
  localparam [7:0]   LAST   = LAST_I[7:0];

  reg [7:0] cnt_q;
  reg       tick_q;

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (cnt_q == LAST);
      if (cnt_q == LAST)
        cnt_q <= 8'h00;
      else
        cnt_q <= cnt_q + 8'h01;
    end
  end

  assign tick_out = tick_q;
endmodule
`default_nettype wire

// file: pin_sync_edge.v
// Purpose: Two-flop synchroniser with strobed rising-edge detection
// Assumes: Input is asynchronous to clk_in
// Notes:   Edge is judged only between strobes, so pulses shorter than one
// Notes:   strobe period may be missed
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // Asynchronous input and sample strobe
  input  wire       async_in,
  input  wire       strobe_in,
  // Synchronised level and rising edge pulse
  output wire       level_out,
  output wire       rise_out
);
  reg meta_q;
  reg sync_q;
  reg samp_q;
  reg rise_q;

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      samp_q <= 1'b0;
      rise_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      rise_q <= strobe_in & sync_q & ~samp_q;
      if (strobe_in)
        samp_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = rise_q;
endmodule
`default_nettype wire

// file: sar_adc_defs.vh
// Purpose: Shared constants of the successive-approximation converter control
// Assumes: Eight-bit special function register bus, machine-cycle timing
// Notes:   Included by bare name from the sequencer, checker and test files
`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH

// Special function register addresses
`define ADDR_CTL0       8'hF8
`define ADDR_RESH       8'hE2
`define ADDR_CTL1       8'hE1

// Control register zero fields
`define CTL0_RES1       7
`define CTL0_RES0       6
`define CTL0_EXT        5
`define CTL0_DONE       4
`define CTL0_START      3
`define CTL0_CH_HI      2
`define CTL0_CH_LO      0

// Control register one fields
`define CTL1_PWR        7
`define CTL1_CLKSEL     1
`define CTL1_BG         0
`define CTL1_RSV_W      5

// Reset values
`define RST_BYTE        8'h00
`define RST_CH          3'h0
`define RST_SAR         10'h000
`define RST_CNT         6'h00

// Conversion schedule in machine cycles
`define INIT_MC         6'h02
`define SAMPLE_MC       6'h08
`define TOTAL_MC        6'h23

// Approximation register
`define SAR_MSB         10'h200
`define SAR_TOP_IDX     4'h9
`define BIT_LAST_STEP   2'h3
`define CONV_DIV_LAST   2'h3

`endif

// file: sar_adc_far_side.sv
// Purpose: Comparator and RC oscillator facing the sequencer
// Assumes: Analog input is a code plus half a step
// Notes:   Half-step offset makes the ideal result equal the code
`timescale 1ns/1ps
`default_nettype none
module sar_adc_far_side (
  // Analog input and ladder level
  input  wire logic [9:0] vin_code_in,
  input  wire logic [9:0] dac_level_in,
  // Comparator and oscillator
  output var  logic       comparator_out,
  output var  logic       rc_clk_out
);
  always @*
    comparator_out = (vin_code_in >= dac_level_in);
  // Period unrelated to the system clock
  initial
  begin
    rc_clk_out = 1'b0;
    forever #5.3 rc_clk_out = ~rc_clk_out;
  end
endmodule
`default_nettype wire

// file: sar_adc_sequencer.v
// Purpose: Start, sequencing, approximation and result registers of a 10-bit converter
// Assumes: Special function register bus on clk_in, analog ladder and comparator outside
// Notes:   All schedule counts are machine-cycle ticks of the internal divider
// Function
// - External start disabled: only a software set of start bit begins conversion.
// - External start enabled: software set or trigger pin rising edge starts.
// - Pin rising edge seen at cycle end; conversion begins next cycle. Here it begins one cycle later, the edge parked in the command flop.
// - Software start begins at the machine cycle after the setting write.
// - Start bit is a command flop for writes and a status flop for reads.
// - Two machine cycles of converter initialisation precede sampling.
// - Status flag rises after first init cycle, stays high while converting.
// - Sampling begins after second init cycle and lasts eight cycles.
// - Approximation starts with only the top bit set, kept if input higher.
// - Each lower bit is trialled and kept or cleared until ten are resolved.
// - Each bit trial takes four converter clock steps.
// - Completion sets the done flag in bit 4 of control register zero.
// - Result bits 9..2 go to the upper register, bits 1,0 to bits 7,6.
// - Done set and status cleared 35 machine cycles after the start.
// - Control bits 2..0 select one of eight analog inputs.
// - Start requests during a running conversion have no effect.
// - Entering Idle or Power-down aborts a conversion in progress.
// - A completed result is kept while the done flag stays set.
// - With the converter disabled its register bits are unavailable.
// - With external start enabled the pin still starts conversions in Idle.
// - Result code runs from 000H at bottom to 3FFH at top.
// - Software clearing the start bit aborts the running conversion.
// - No new conversion starts while status or done flag is set.
// - Power-enable bit switches the converter circuit on and off.
// - Clock-select picks system clock by four or RC oscillator by two.
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defs.vh"
module sar_adc_sequencer #(
  parameter CLKS_PER_MC = 12
) (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // Special function register bus
  input  wire [7:0] sfr_addr_in,
  input  wire       sfr_wr_in,
  input  wire [7:0] sfr_wdata_in,
  output wire [7:0] sfr_rdata_out,
  // Processor power modes
  input  wire       idle_in,
  input  wire       power_down_in,
  // Pins and analog side
  input  wire       trigger_input_pin_in,
  input  wire       comparator_in,
  input  wire       rc_clk_in,
  output wire [2:0] channel_select_out,
  output wire       bandgap_select_out,
  output wire [9:0] dac_compare_level_out,
  output wire       converter_power_enable_out,
  output wire       sample_enable_out,
  // Status to the core
  output wire       conversion_irq_out,
  output wire       converter_busy_out
);
  localparam [1:0] ST_IDLE   = 2'd0;
  localparam [1:0] ST_INIT   = 2'd1;
  localparam [1:0] ST_SAMPLE = 2'd2;
  localparam [1:0] ST_CONV   = 2'd3;

  reg  [1:0] state_q;
  reg  [5:0] mc_cnt_q;
  reg        cmd_q;
  reg        status_q;
  reg        done_q;
  reg        ext_en_q;
  reg  [2:0] chan_q;
  reg  [7:0] ctl1_q;
  reg  [7:0] res_hi_q;
  reg  [1:0] res_lo_q;
  reg  [9:0] sar_q;
  reg  [3:0] bit_idx_q;
  reg  [1:0] step_q;
  reg        approx_q;
  reg  [1:0] div_q;
  reg        rc_half_q;
  reg        idle_q;
  reg        pd_q;
  reg  [7:0] rdata_q;
  reg  [7:0] rdata_d;

  wire       mc_tick;
  wire       trig_rise;
  wire       comp_level;
  wire       rc_rise;
  wire [9:0] sar_next;

  machine_cycle_tick #(
    .CLKS_PER_MC (CLKS_PER_MC)
  ) u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .tick_out (mc_tick)
  );

  // Pin is sampled once per machine cycle, at its end
  pin_sync_edge u_trig (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (trigger_input_pin_in),
    .strobe_in (mc_tick),
    .level_out (),
    .rise_out  (trig_rise)
  );

  pin_sync_edge u_comp (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (comparator_in),
    .strobe_in (1'b1),
    .level_out (comp_level),
    .rise_out  ()
  );

  pin_sync_edge u_rc (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (rc_clk_in),
    .strobe_in (1'b1),
    .level_out (),
    .rise_out  (rc_rise)
  );

  wire power    = ctl1_q[`CTL1_PWR];
  wire running  = (state_q != ST_IDLE);
  wire hit_ctl0 = (sfr_addr_in == `ADDR_CTL0);
  wire hit_resh = (sfr_addr_in == `ADDR_RESH);
  wire hit_ctl1 = (sfr_addr_in == `ADDR_CTL1);

  // Control register zero is dead while the converter is off
  wire wr_ctl0   = sfr_wr_in & hit_ctl0 & power;
  wire wr_ctl1   = sfr_wr_in & hit_ctl1;
  wire sw_set    = wr_ctl0 & sfr_wdata_in[`CTL0_START];
  wire sw_clear  = wr_ctl0 & ~sfr_wdata_in[`CTL0_START] & (running | cmd_q);
  wire done_clr  = wr_ctl0 & ~sfr_wdata_in[`CTL0_DONE];

  // Clearing done in the same write as a start lets the start through
  wire can_start = ~running & ~cmd_q & ~status_q & (~done_q | done_clr);
  wire pin_start = power & ext_en_q & trig_rise & ~running & ~status_q & ~done_q;

  // Entry edges of the low-power modes
  wire mode_entry = (idle_in & ~idle_q) | (power_down_in & ~pd_q);
  wire abort      = mode_entry | sw_clear | ~power;

  // Command flop launches at the next machine cycle boundary
  // The pin edge flag comes a clock after the tick, so it is parked in the command flop
  wire launch   = ~running & mc_tick & cmd_q & ~abort;
  wire conv_end = (state_q == ST_CONV) & mc_tick & (mc_cnt_q == `TOTAL_MC - 6'h01);

  // Converter clock: fsys/4 or RC/2
  wire conv_tick = ctl1_q[`CTL1_CLKSEL] ? (rc_rise & rc_half_q) : (div_q == `CONV_DIV_LAST);
  wire trial_end = approx_q & conv_tick & (step_q == `BIT_LAST_STEP);

  // Keep or drop the bit under trial, then raise the next lower one
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1)
    begin : g_sar
      assign sar_next[gi] = (bit_idx_q == gi) ? (sar_q[gi] & comp_level) :
                            ((bit_idx_q == gi + 1) ? 1'b1 : sar_q[gi]);
    end
  endgenerate

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_q     <= 2'h0;
      rc_half_q <= 1'b0;
      idle_q    <= 1'b0;
      pd_q      <= 1'b0;
    end
    else
    begin
      div_q  <= div_q + 2'h1;
      idle_q <= idle_in;
      pd_q   <= power_down_in;
      if (rc_rise)
        rc_half_q <= ~rc_half_q;
    end
  end

  // Software-visible bits
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cmd_q    <= 1'b0;
      done_q   <= 1'b0;
      ext_en_q <= 1'b0;
      chan_q   <= `RST_CH;
      ctl1_q   <= `RST_BYTE;
    end
    else
    begin
      if (wr_ctl1)
      begin
        ctl1_q <= sfr_wdata_in;
        ctl1_q[`CTL1_RSV_W+1:`CTL1_CLKSEL+1] <= 5'h00;
      end
      if (wr_ctl0)
        ext_en_q <= sfr_wdata_in[`CTL0_EXT];
      // Channel is frozen while busy or a result waits
      if (wr_ctl0 & ~running & ~status_q & ~done_q & ~cmd_q)
        chan_q <= sfr_wdata_in[`CTL0_CH_HI:`CTL0_CH_LO];
      // Command flop, separate from the status flop
      if (abort | launch)
        cmd_q <= 1'b0;
      else if ((sw_set & can_start) | pin_start)
        cmd_q <= 1'b1;
      // Hardware set wins over a software clear
      if (conv_end)
        done_q <= 1'b1;
      else if (done_clr)
        done_q <= 1'b0;
    end
  end

  // Conversion sequence
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q   <= ST_IDLE;
      mc_cnt_q  <= `RST_CNT;
      status_q  <= 1'b0;
      res_hi_q  <= `RST_BYTE;
      res_lo_q  <= 2'h0;
      sar_q     <= `RST_SAR;
      bit_idx_q <= 4'h0;
      step_q    <= 2'h0;
      approx_q  <= 1'b0;
    end
    else if (abort & (running | cmd_q))
    begin
      state_q  <= ST_IDLE;
      mc_cnt_q <= `RST_CNT;
      status_q <= 1'b0;
      approx_q <= 1'b0;
    end
    else
    begin
      if (launch)
      begin
        state_q  <= ST_INIT;
        mc_cnt_q <= `RST_CNT;
      end
      else if (running & mc_tick)
        mc_cnt_q <= mc_cnt_q + 6'h01;
      case (state_q)
        ST_INIT:
        begin
          if (mc_tick & (mc_cnt_q == `RST_CNT))
            status_q <= 1'b1;
          if (mc_tick & (mc_cnt_q == `INIT_MC - 6'h01))
            state_q <= ST_SAMPLE;
        end
        ST_SAMPLE:
        begin
          if (mc_tick & (mc_cnt_q == `INIT_MC + `SAMPLE_MC - 6'h01))
          begin
            state_q   <= ST_CONV;
            sar_q     <= `SAR_MSB;
            bit_idx_q <= `SAR_TOP_IDX;
            step_q    <= 2'h0;
            approx_q  <= 1'b1;
          end
        end
        ST_CONV:
        begin
          if (approx_q & conv_tick)
            step_q <= step_q + 2'h1;
          if (trial_end)
          begin
            sar_q <= sar_next;
            if (bit_idx_q == 4'h0)
              approx_q <= 1'b0;
            else
              bit_idx_q <= bit_idx_q - 4'h1;
          end
          // Result registers change only here, and never while done is set
          if (conv_end)
          begin
            state_q  <= ST_IDLE;
            status_q <= 1'b0;
            approx_q <= 1'b0;
            res_hi_q <= sar_q[9:2];
            res_lo_q <= sar_q[1:0];
          end
        end
        default:
        begin
          status_q <= status_q;
        end
      endcase
    end
  end

  // Read data registered; unmapped or disabled addresses read zero
  always @*
  begin
    rdata_d = `RST_BYTE;
    if (hit_ctl0 & power)
      rdata_d = {res_lo_q[1], res_lo_q[0], ext_en_q, done_q, status_q, chan_q};
    else if (hit_resh & power)
      rdata_d = res_hi_q;
    else if (hit_ctl1)
      rdata_d = ctl1_q;
  end

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_q <= `RST_BYTE;
    else
      rdata_q <= rdata_d;
  end

  assign sfr_rdata_out              = rdata_q;
  assign channel_select_out         = chan_q;
  assign bandgap_select_out         = ctl1_q[`CTL1_BG];
  assign dac_compare_level_out      = sar_q;
  assign converter_power_enable_out = power;
  assign sample_enable_out          = (state_q == ST_SAMPLE);
  assign conversion_irq_out         = done_q;
  assign converter_busy_out         = status_q;
endmodule
`default_nettype wire

// file: sar_adc_sequencer_assertions.sv
// Purpose: Port checks of the converter sequencer
// Assumes: CLKS_PER_MC system clocks per machine cycle
// Notes:   Sample length check assumes no abort inside the sample phase
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defs.vh"
module sar_adc_sequencer_checker #(
  parameter CLKS_PER_MC = 12
) (
  // Clock, reset and register bus
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  // Converter outputs
  input wire logic [2:0] channel_select_out,
  input wire logic [9:0] dac_compare_level_out,
  input wire logic       converter_power_enable_out,
  input wire logic       sample_enable_out,
  input wire logic       conversion_irq_out,
  input wire logic       converter_busy_out
);
  localparam int BUSY_LO  = 34 * CLKS_PER_MC - 2;
  localparam int BUSY_HI  = 34 * CLKS_PER_MC + 1;
  localparam int SMP_LAST = 8 * CLKS_PER_MC - 1;
  logic [9:0] busy_cnt_q;
  wire        wr0 = sfr_wr_in && (sfr_addr_in == `ADDR_CTL0);
  wire        wr1 = sfr_wr_in && (sfr_addr_in == `ADDR_CTL1);
  // Counts busy clocks so the 35-cycle schedule is checked without long delays
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      busy_cnt_q <= 10'h000;
    else
      busy_cnt_q <= converter_busy_out ? busy_cnt_q + 10'h001 : 10'h000;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_done_ends_busy;
    $rose(conversion_irq_out) |-> $fell(converter_busy_out);
  endproperty
  a_done_ends_busy: assert property (p_done_ends_busy) else $error("done without busy end");
  property p_conv_time;
    $rose(conversion_irq_out) |-> busy_cnt_q >= BUSY_LO && busy_cnt_q <= BUSY_HI;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("busy length wrong");
  property p_sample_len;
    $rose(sample_enable_out) |-> ##SMP_LAST sample_enable_out ##1 !sample_enable_out;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample phase length wrong");
  property p_msb_first;
    $fell(sample_enable_out) && converter_busy_out |-> ##[0:1] dac_compare_level_out == `SAR_MSB;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first trial not top bit");
  property p_done_holds;
    conversion_irq_out && !(wr0 && !sfr_wdata_in[`CTL0_DONE]) && !wr1 |=> conversion_irq_out;
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("done dropped");
  property p_result_kept;
    conversion_irq_out && $past(conversion_irq_out) |-> $stable(dac_compare_level_out);
  endproperty
  a_result_kept: assert property (p_result_kept) else $error("result changed");
  property p_power_bit;
    wr1 |=> converter_power_enable_out == $past(sfr_wdata_in[`CTL1_PWR]);
  endproperty
  a_power_bit: assert property (p_power_bit) else $error("power bit wrong");
  property p_off_reads_zero;
    !converter_power_enable_out && !$past(converter_power_enable_out) && $past(sfr_addr_in) == `ADDR_CTL0
      |-> sfr_rdata_out == 8'h00;
  endproperty
  a_off_reads_zero: assert property (p_off_reads_zero) else $error("read while off");
  property p_channel_locked;
    $changed(channel_select_out) |-> !$past(converter_busy_out) && !$past(conversion_irq_out);
  endproperty
  a_channel_locked: assert property (p_channel_locked) else $error("channel changed");
  c_done: cover property ($rose(conversion_irq_out));
  c_abort: cover property ($fell(converter_busy_out) && !conversion_irq_out);
  c_sample: cover property ($rose(sample_enable_out));
endmodule
bind sar_adc_sequencer sar_adc_sequencer_checker #(.CLKS_PER_MC(CLKS_PER_MC)) chk_u (
  .clk_in, .rst_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out, .channel_select_out,
  .dac_compare_level_out, .converter_power_enable_out, .sample_enable_out, .conversion_irq_out,
  .converter_busy_out);
`default_nettype wire

// file: test_sar_adc_sequencer.sv
// Purpose: Register level test of the converter sequencer
// Assumes: Twelve clocks per machine cycle, inputs driven 1 ns after the edge
// Notes:   Aborts fall after the sample phase
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defs.vh"
module test_sar_adc_sequencer;
  localparam MC = 12;
  logic       clk_in, rst_in, sfr_wr_in, idle_in, power_down_in, pin;
  logic [7:0] sfr_addr_in, sfr_wdata_in, rd_q;
  logic [9:0] vin;
  wire  [7:0] rdata;
  wire  [9:0] dac;
  wire  [2:0] chan;
  wire        cmp, rc, irq, busy, bg;
  int         fails, n_tests, el;
  longint     t0;
  logic [9:0] vins [8] = '{10'h000, 10'h3FF, 10'h200, 10'h1FF, 10'h155, 10'h2AA, 10'h001, 10'h3FE};
  logic [7:0] addrs [4] = '{`ADDR_CTL0, `ADDR_RESH, `ADDR_CTL1, 8'h55};
  sar_adc_sequencer #(.CLKS_PER_MC(MC)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(rdata), .idle_in(idle_in), .power_down_in(power_down_in),
    .trigger_input_pin_in(pin), .comparator_in(cmp), .rc_clk_in(rc), .channel_select_out(chan),
    .bandgap_select_out(bg), .dac_compare_level_out(dac), .converter_power_enable_out(),
    .sample_enable_out(), .conversion_irq_out(irq), .converter_busy_out(busy));
  sar_adc_far_side far (.vin_code_in(vin), .dac_level_in(dac), .comparator_out(cmp), .rc_clk_out(rc));
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic stop_test();
    $display("TB: %0d mismatches in %0d checks", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    clks(1);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    clks(1);
    sfr_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    clks(1);
    sfr_addr_in = a;
    clks(1);
    rd_q = rdata;
  endtask
  // Bounded wait; el is clocks since t0
  task automatic wait_done();
    for (int c = 0; c < 1000 && irq !== 1'b1; c++)
      clks(1);
    // A run-out is a mismatch; the closing report still comes from the main sequence
    if (irq !== 1'b1)
      fails++;
    el = int'(($time - t0) / 4);
  endtask
  // Powered down: start ignored, every register reads zero
  task automatic check_off();
    wr(`ADDR_CTL0, 8'h08);
    clks(30);
    chk(busy, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      rd(addrs[k]);
      chk(rd_q, 8'h00);
    end
  endtask
  initial
  begin
    fails = 0;
    n_tests = 0;
    {rst_in, sfr_wr_in, idle_in, power_down_in, pin} = 5'h10;
    {sfr_addr_in, sfr_wdata_in, vin} = 26'h000_0000;
    clks(16);
    rst_in = 1'b0;
    check_off();
    for (int i = 0; i < 8; i++)
    begin
      vin = vins[i];
      wr(`ADDR_CTL1, {6'h3F, i[0], i[1]});
      rd(`ADDR_CTL1);
      chk(rd_q, {6'h20, i[0], i[1]});
      chk(bg, i[1]);
      wr(`ADDR_CTL0, {5'h01, i[2:0]});
      t0 = $time;
      clks(150);
      wr(`ADDR_CTL0, {5'h01, ~i[2:0]});
      rd(`ADDR_CTL0);
      chk(rd_q[3:0], {1'b1, i[2:0]});
      wait_done();
      chk(10'(el >= 418 && el <= 436), 10'h001);
      idle_in = 1'b1;
      rd(`ADDR_RESH);
      chk(rd_q, vin[9:2]);
      rd(`ADDR_CTL0);
      chk(rd_q, {vin[1:0], 3'h2, i[2:0]});
      chk(chan, i[2:0]);
      wr(`ADDR_CTL0, {5'h03, i[2:0]});
      clks(40);
      chk(busy, 1'b0);
      chk(irq, 1'b1);
      idle_in = 1'b0;
      wr(`ADDR_CTL0, {5'h00, i[2:0]});
      chk(irq, 1'b0);
    end
    for (int k = 0; k < 3; k++)
    begin
      vin = vins[k + 4];
      wr(`ADDR_CTL0, {2'h0, k != 0, 5'h00});
      idle_in = (k == 2);
      pin = 1'b0;
      clks(2 * MC);
      pin = 1'b1;
      t0 = $time;
      if (k == 0)
      begin
        clks(4 * MC);
        chk(busy, 1'b0);
      end
      else
      begin
        wait_done();
        chk(10'(el >= 425 && el <= 452), 10'h001);
        rd(`ADDR_RESH);
        chk(rd_q, vin[9:2]);
        wr(`ADDR_CTL0, 8'h20);
      end
      idle_in = 1'b0;
    end
    for (int k = 0; k < 3; k++)
    begin
      wr(`ADDR_CTL0, 8'h08);
      clks(200);
      chk(busy, 1'b1);
      if (k == 0)
        wr(`ADDR_CTL0, 8'h00);
      else if (k == 1)
        idle_in = 1'b1;
      else
        power_down_in = 1'b1;
      clks(3);
      chk(busy, 1'b0);
      clks(400);
      chk(irq, 1'b0);
      idle_in = 1'b0;
      power_down_in = 1'b0;
    end
    wr(`ADDR_CTL1, 8'h00);
    check_off();
    stop_test();
  end
endmodule
`default_nettype wire
